// file: design/cmw_top.sv
// Clock mode selection, power-down and wake-up sequencer with APB registers
//
// The register addresses and register access over APB were decided locally.
`default_nettype none
module cmw_top
  import cmw_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int RESTART = CMW_RESTART_CYCLES,
  parameter bit SUB_FROM_XTAL = 1'b1, // Sub clock from crystal, else RC
  parameter bit AUX_FROM_SUB = 1'b1,  // Aux clock from sub, else core/4
  parameter bit WDT_OWN_OSC = 1'b1    // Watchdog on its own oscillator
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Low oscillator ticks
  input wire logic i_rc32k_tick,
  input wire logic i_xtal32k_tick,
  // Core side events
  input wire logic i_halt,
  input wire logic i_wdt_clear,
  input wire logic i_wdt_overflow,
  input wire logic i_ext_reset_req,
  input wire logic i_irq_req,
  input wire logic i_irq_enabled,
  input wire logic i_stack_full,
  input wire logic [PORT_W-1:0] i_port_a,
  // Clock enables
  output logic o_core_clk_en,
  output logic o_sub_clk_en,
  output logic o_display_clk_en,
  output logic o_aux_clk_en,
  output logic o_fast_osc_on,
  // Core control
  output logic o_cpu_run,
  output logic o_wdt_clear,
  output logic o_wdt_run,
  output logic o_system_reset,
  output logic o_wdt_reset,
  output logic o_pcsp_reset,
  output logic o_resume,
  output logic o_irq_take
);
  localparam int CW = $clog2(RESTART);
  localparam logic [CW-1:0] RESTART_LAST = CW'(RESTART - 1);

  typedef struct packed {
    cmw_state_e state;        // Sequencer state
    cmw_src_e src;            // Last wake cause
    logic fast_slow;          // 1 = core on fast clock
    logic idle_en;            // Halt goes to idle, else sleep
    logic disp_en;            // Display clock enable
    logic [2:0] slow_sel;     // Slow divider select
    logic [PORT_W-1:0] wmask; // Port wake enables
    logic powerdown_flag;                // Powerdown flag
    logic to;                 // Watchdog timeout flag
    logic irq_at_entry;       // Irq pending when halted
    logic idle_mode;          // Captured idle choice
    logic [CW-1:0] rcnt;      // Restart wait counter
    logic [5:0] scnt;         // Fast clock prescaler
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_en;
    logic sub_en;
    logic disp_clk;
    logic aux_clk;
    logic fast_on;
    logic cpu_run;
    logic wdt_clear;
    logic wdt_run;
    logic sys_reset;
    logic wdt_reset;
    logic pcsp_reset;
    logic resume;
    logic irq_take;
  } cmw_top_s;

  cmw_top_s st;
  cmw_top_s next_st;

  logic low_tick;   // Selected low oscillator tick
  logic disp_tick;  // Sub clock over eight
  logic core_div4;  // Core clock over four
  logic port_wake;  // Enabled port falling edge
  logic slow_tick;  // Slow system clock tick
  logic [5:0] smask; // Prescaler terminal mask
  logic core_tick;  // Core tick in the chosen mode
  logic slow0;      // Slow mode on the low oscillator
  logic irq_wake;   // Interrupt able to wake
  logic setup;      // APB setup cycle
  logic access;     // APB access with pready
  logic [2:0] mode; // Reported operating mode

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  assign low_tick = SUB_FROM_XTAL ? i_xtal32k_tick : i_rc32k_tick;

  // Display clock divider
  cmw_div #(.DIV(CMW_DISP_DIV)) u_disp_div (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_tick(low_tick),
    .o_tick(disp_tick)
  );

  // Core over four for the aux clock
  cmw_div #(.DIV(CMW_AUX_DIV)) u_aux_div (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_tick(st.core_en),
    .o_tick(core_div4)
  );

  // Port falling edge wake
  cmw_edge_wake #(.N(PORT_W)) u_port_wake (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pins(i_port_a),
    .i_mask(st.wmask),
    .o_wake(port_wake)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock derivation
  always_comb begin
    smask = 6'h3F >> (3'h5 - st.slow_sel);
    slow0 = (st.slow_sel >= CMW_SLOW_SEL_LOW_OSC);
    slow_tick = slow0 ? low_tick : ((st.scnt & smask) == smask);
    core_tick = st.fast_slow ? 1'b1 : slow_tick;
    irq_wake = i_irq_req & ~st.irq_at_entry;
    setup = i_psel & ~i_penable;
    access = i_psel & i_penable & st.pready;
    // Mode from select bit, idle bit and halt
    mode = (st.state == CMW_ST_DOWN) ? (st.idle_mode ? CMW_MODE_IDLE : CMW_MODE_SLEEP)
         : (st.fast_slow ? CMW_MODE_NORMAL : (slow0 ? CMW_MODE_SLOW0 : CMW_MODE_SLOW1));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Pulses default low
    next_st.wdt_clear = 1'b0;
    next_st.sys_reset = 1'b0;
    next_st.wdt_reset = 1'b0;
    next_st.pcsp_reset = 1'b0;
    next_st.resume = 1'b0;
    next_st.irq_take = 1'b0;
    next_st.scnt = st.scnt + 6'h01;

    // APB register access
    next_st.pready = 1'b1;
    if (setup) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      unique case (i_paddr)
        CMW_OFS_CLOCK_MODE: begin
          next_st.prdata[CMW_BIT_FAST_SLOW] = st.fast_slow;
          next_st.prdata[CMW_BIT_IDLE_EN] = st.idle_en;
          next_st.prdata[CMW_BIT_DISP_EN] = st.disp_en;
          next_st.prdata[CMW_SLOW_SEL_MSB:CMW_SLOW_SEL_LSB] = st.slow_sel;
        end
        CMW_OFS_WAKE_MASK: next_st.prdata[PORT_W-1:0] = st.wmask;
        CMW_OFS_STATUS: begin
          next_st.prdata[CMW_BIT_PDF] = st.powerdown_flag;
          next_st.prdata[CMW_BIT_TO] = st.to;
          next_st.prdata[CMW_MODE_MSB:CMW_MODE_LSB] = mode;
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (access && i_pwrite) begin
      if (i_paddr == CMW_OFS_CLOCK_MODE) begin
        next_st.fast_slow = i_pwdata[CMW_BIT_FAST_SLOW];
        next_st.idle_en = i_pwdata[CMW_BIT_IDLE_EN];
        next_st.disp_en = i_pwdata[CMW_BIT_DISP_EN];
        next_st.slow_sel = i_pwdata[CMW_SLOW_SEL_MSB:CMW_SLOW_SEL_LSB];
      end else if (i_paddr == CMW_OFS_WAKE_MASK) begin
        next_st.wmask = i_pwdata[PORT_W-1:0];
      end
    end

    // Watchdog clear instruction drops the powerdown flag
    if (i_wdt_clear) begin
      next_st.powerdown_flag = 1'b0;
    end
    // Sequencer
    unique case (st.state)
      CMW_ST_RUN: begin
        if (i_ext_reset_req) begin
          next_st.sys_reset = 1'b1;
        end else if (i_wdt_overflow) begin
          next_st.to = 1'b1;
          next_st.wdt_reset = 1'b1;
        end else if (i_halt) begin
          // Power-down entry only through halt
          next_st.state = CMW_ST_DOWN;
          next_st.powerdown_flag = 1'b1;
          next_st.to = 1'b0;
          next_st.wdt_clear = 1'b1;
          next_st.irq_at_entry = i_irq_req;
          next_st.idle_mode = st.idle_en;
        end
      end
      CMW_ST_DOWN: begin
        next_st.rcnt = '0;
        if (i_ext_reset_req) begin
          next_st.sys_reset = 1'b1;
          next_st.src = CMW_SRC_RESET;
          next_st.state = CMW_ST_WAIT;
        end else if (i_wdt_overflow) begin
          next_st.to = 1'b1;
          next_st.pcsp_reset = 1'b1;
          next_st.src = CMW_SRC_WDT;
          next_st.state = CMW_ST_WAIT;
        end else if (port_wake) begin
          next_st.src = CMW_SRC_PORT;
          next_st.state = CMW_ST_WAIT;
        end else if (irq_wake) begin
          next_st.src = CMW_SRC_IRQ;
          next_st.state = CMW_ST_WAIT;
        end
      end
      CMW_ST_WAIT: begin // Restart wait counted in core clocks
        if (core_tick) begin
          if (st.rcnt == RESTART_LAST) begin
            if (st.src == CMW_SRC_IRQ) begin
              next_st.state = CMW_ST_GAP;
            end else begin
              next_st.state = CMW_ST_RUN;
              next_st.resume = 1'b1;
            end
          end else begin
            next_st.rcnt = st.rcnt + CW'(1);
          end
        end
      end
      CMW_ST_GAP: begin // Extra core cycle before the interrupt response
        if (core_tick) begin
          next_st.state = CMW_ST_RUN;
          next_st.resume = 1'b1;
          next_st.irq_take = i_irq_enabled & ~i_stack_full;
        end
      end
    endcase
    // Registered clock enables and status outputs
    next_st.core_en = (st.state != CMW_ST_DOWN) & core_tick;
    next_st.cpu_run = (next_st.state == CMW_ST_RUN);
    next_st.fast_on = (next_st.state != CMW_ST_DOWN)
                      & (next_st.fast_slow | ~slow0);
    next_st.wdt_run = WDT_OWN_OSC | (st.state != CMW_ST_DOWN);
    next_st.sub_en = low_tick;
    next_st.disp_clk = disp_tick & st.disp_en
                       & ~((st.state == CMW_ST_DOWN) & ~st.idle_mode);
    next_st.aux_clk = (AUX_FROM_SUB ? low_tick : core_div4)
                      & ~((st.state == CMW_ST_DOWN) & ~st.idle_mode);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
      st.state <= CMW_ST_RUN;
      st.src <= CMW_SRC_RESET;
      st.fast_slow <= CMW_RST_FAST_SLOW;
      st.slow_sel <= CMW_RST_SLOW_SEL;
      st.wmask <= PORT_W'(CMW_RST_WAKE_MASK);
      st.pready <= 1'b1;
      st.cpu_run <= 1'b1;
      st.fast_on <= 1'b1;
      st.wdt_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_core_clk_en = st.core_en;
  assign o_sub_clk_en = st.sub_en;
  assign o_display_clk_en = st.disp_clk;
  assign o_aux_clk_en = st.aux_clk;
  assign o_fast_osc_on = st.fast_on;
  assign o_cpu_run = st.cpu_run;
  assign o_wdt_clear = st.wdt_clear;
  assign o_wdt_run = st.wdt_run;
  assign o_system_reset = st.sys_reset;
  assign o_wdt_reset = st.wdt_reset;
  assign o_pcsp_reset = st.pcsp_reset;
  assign o_resume = st.resume;
  assign o_irq_take = st.irq_take;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_halt_sets_flags: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_RUN && i_halt && !i_ext_reset_req && !i_wdt_overflow)
    |=> (st.powerdown_flag && !st.to && o_wdt_clear && !o_cpu_run))
    else $error("halt did not set powerdown state");
  chk_only_halt_down: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_RUN && !i_halt) |=> (st.state != CMW_ST_DOWN))
    else $error("power-down entered without halt");
  chk_wdt_wake_to: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_DOWN && i_wdt_overflow && !i_ext_reset_req)
    |=> (st.to && o_pcsp_reset && !o_wdt_reset))
    else $error("watchdog wake did not reset pc and sp only");
  chk_stale_irq_blocked: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_DOWN && st.irq_at_entry && !port_wake
     && !i_ext_reset_req && !i_wdt_overflow) |=> (st.state == CMW_ST_DOWN))
    else $error("pending irq woke the device");
  chk_wait_fast_len: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_DOWN && port_wake && st.fast_slow && !i_ext_reset_req
     && !i_wdt_overflow) |=> (st.state == CMW_ST_WAIT) [*8] ##1 !o_resume)
    else $error("restart wait ended early");
  chk_wait_end_resume: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_WAIT && core_tick && st.rcnt == RESTART_LAST
     && st.src != CMW_SRC_IRQ) |=> (o_resume && st.state == CMW_ST_RUN))
    else $error("resume missing at end of wait");
  chk_irq_gap: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_irq_take) |-> ($past(st.state, 2) == CMW_ST_GAP
      || $past(st.state) == CMW_ST_GAP))
    else $error("irq taken without extra cycle");
  chk_display_gate: assert property (@(posedge i_clk) disable iff (i_reset)
    o_display_clk_en |-> $past(st.disp_en)) else $error("display clock ran while disabled");
  chk_sleep_aux_off: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_DOWN && !st.idle_mode) |=> (!o_aux_clk_en && !o_display_clk_en))
    else $error("aux or display clock ran in sleep");
  chk_down_core_off: assert property (@(posedge i_clk) disable iff (i_reset)
    (st.state == CMW_ST_DOWN) |=> !o_core_clk_en) else $error("core clock ran in power-down");
endmodule : cmw_top
`default_nettype wire

// file: design/cmw_pkg.sv
// Shared constants for the clock mode and wake-up controller
`default_nettype none
package cmw_pkg;
  // Register byte offsets
  localparam logic [7:0] CMW_OFS_CLOCK_MODE = 8'h00;
  localparam logic [7:0] CMW_OFS_WAKE_MASK = 8'h04;
  localparam logic [7:0] CMW_OFS_STATUS = 8'h08;
  // Clock mode register fields
  localparam int CMW_BIT_FAST_SLOW = 0;
  localparam int CMW_BIT_IDLE_EN = 1;
  localparam int CMW_BIT_DISP_EN = 2;
  localparam int CMW_SLOW_SEL_LSB = 3;
  localparam int CMW_SLOW_SEL_MSB = 5;
  // Status register fields
  localparam int CMW_BIT_PDF = 0;
  localparam int CMW_BIT_TO = 1;
  localparam int CMW_MODE_LSB = 2;
  localparam int CMW_MODE_MSB = 4;
  // Reset values
  localparam logic CMW_RST_FAST_SLOW = 1'h1;
  localparam logic [2:0] CMW_RST_SLOW_SEL = 3'h0;
  localparam logic [7:0] CMW_RST_WAKE_MASK = 8'h00;
  // Slow divider select: codes below this one divide the fast clock by 2..64
  localparam logic [2:0] CMW_SLOW_SEL_LOW_OSC = 3'h6;
  // Reported operating modes
  localparam logic [2:0] CMW_MODE_NORMAL = 3'h0;
  localparam logic [2:0] CMW_MODE_SLOW0 = 3'h1;
  localparam logic [2:0] CMW_MODE_SLOW1 = 3'h2;
  localparam logic [2:0] CMW_MODE_IDLE = 3'h3;
  localparam logic [2:0] CMW_MODE_SLEEP = 3'h4;
  // Fixed clock ratios
  localparam int CMW_DISP_DIV = 8;
  localparam int CMW_AUX_DIV = 4;
  localparam int CMW_RESTART_CYCLES = 1024;
  // Sequencer states, Gray coded along run, down, wait, gap
  typedef enum logic [1:0] {
    CMW_ST_RUN = 2'h0,
    CMW_ST_DOWN = 2'h1,
    CMW_ST_WAIT = 2'h3,
    CMW_ST_GAP = 2'h2
  } cmw_state_e;
  // Cause of the last wake-up
  typedef enum logic [1:0] {
    CMW_SRC_RESET = 2'h0,
    CMW_SRC_WDT = 2'h1,
    CMW_SRC_PORT = 2'h2,
    CMW_SRC_IRQ = 2'h3
  } cmw_src_e;
endpackage : cmw_pkg
`default_nettype wire

// file: design/cmw_div.sv
// Fixed ratio divider of an enable pulse stream
`default_nettype none
module cmw_div
  import cmw_pkg::*;
#(
  parameter int DIV = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pulse in and divided pulse out
  input wire logic i_tick,
  output logic o_tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt; // Input pulses seen
    logic tick;         // Output pulse
  } cmw_div_s;

  cmw_div_s st;
  cmw_div_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Count input pulses and pulse once per DIV of them
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (i_tick) begin
      if (st.cnt == LAST) begin
        next_st.cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;
endmodule : cmw_div
`default_nettype wire

// file: design/cmw_edge_wake.sv
// Per-pin falling edge wake detector for the port
`default_nettype none
module cmw_edge_wake
  import cmw_pkg::*;
#(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pins and per-pin enable
  input wire logic [N-1:0] i_pins,
  input wire logic [N-1:0] i_mask,
  // Any enabled pin fell
  output logic o_wake
);
  typedef struct packed {
    logic [N-1:0] prev; // Pin levels one cycle ago
    logic wake;         // Registered wake pulse
  } cmw_edge_s;

  cmw_edge_s st;
  cmw_edge_s next_st;
  logic [N-1:0] fall; // Enabled negative transitions

  ////////////////////////////////////////////////////////////////////////////
  // One falling edge detector per pin
  for (genvar g = 0; g < N; g++) begin : g_pin
    assign fall[g] = st.prev[g] & ~i_pins[g] & i_mask[g];
  end

  // Track pin levels and flag a wake
  always_comb begin
    next_st = st;
    next_st.prev = i_pins;
    next_st.wake = |fall;
  end

  // State register; pins idle high
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '{prev: '1, wake: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_wake = st.wake;
endmodule : cmw_edge_wake
`default_nettype wire

// file: bench/cmw_core_model.sv
// Behavioural processor core driving the controller's event inputs
`default_nettype none
module cmw_core_model (
  // Clock, reset and run status
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cpu_run,
  // Events towards the controller
  output logic o_halt,
  output logic o_wdt_clear,
  output logic o_wdt_overflow,
  output logic o_ext_reset_req,
  output logic o_irq_req,
  output logic o_irq_enabled,
  output logic o_stack_full,
  output logic [7:0] o_port_a
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet levels while reset is held, port pins idle high
  always @(posedge i_clk) begin
    if (i_reset) begin
      {o_halt, o_wdt_clear, o_wdt_overflow, o_ext_reset_req} <= 4'h0;
      {o_irq_req, o_irq_enabled, o_stack_full} <= 3'h0;
      o_port_a <= 8'hFF;
    end
  end
  // One cycle pulse of {reset, overflow, clear}
  task automatic pulse(input logic [2:0] sel);
    @(posedge i_clk);
    {o_ext_reset_req, o_wdt_overflow, o_wdt_clear} <= sel;
    @(posedge i_clk);
    {o_ext_reset_req, o_wdt_overflow, o_wdt_clear} <= 3'h0;
  endtask : pulse
  // Halt only comes from running code
  task automatic halt();
    @(posedge i_clk);
    while (i_cpu_run !== 1'b1) @(posedge i_clk);
    o_halt <= 1'b1;
    @(posedge i_clk);
    o_halt <= 1'b0;
  endtask : halt
  // Pin falls, then returns high
  task automatic fall(input int pin);
    @(posedge i_clk);
    o_port_a[pin] <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_port_a[pin] <= 1'b1;
  endtask : fall
  // Request, enable and stack-full levels
  task automatic irq(input logic [2:0] lv);
    @(posedge i_clk);
    {o_irq_req, o_irq_enabled, o_stack_full} <= lv;
  endtask : irq
endmodule : cmw_core_model
`default_nettype wire

// file: bench/tb_clock_mode_and_wakeup_control.sv
// Self-checking bench of the clock mode and wake-up controller
`default_nettype none
module tb_clock_mode_and_wakeup_control;
  import cmw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RST = 16; // Shortened restart wait
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tick = 1'b0;
  logic halt, wclr_in, wovf, xrst, irq, irq_en, sfull;
  logic [7:0] port;
  logic core_en, sub_en, disp, aux, fast_on, cpu_run, wclr, wrun, srst, wrst, pcsp, res, take;
  logic [8:0] ev; // Watched pulses
  int cnt[9], b[9], cyc = 0, t_res = 0, t0, n_errors = 0, samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, low oscillator ticks every fourth cycle, pulse counters
  always #50 i_clk = ~i_clk;
  assign ev = {sub_en, wrst, aux, disp, wclr, srst, pcsp, take, res};
  initial foreach (cnt[i]) cnt[i] = 0;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4 == 3);
    if (res === 1'b1) t_res <= cyc;
    for (int i = 0; i < 9; i++) cnt[i] <= cnt[i] + int'(ev[i] === 1'b1);
  end
  cmw_core_model core (.i_clk(i_clk), .i_reset(i_reset), .i_cpu_run(cpu_run), .o_halt(halt),
    .o_wdt_clear(wclr_in), .o_wdt_overflow(wovf), .o_ext_reset_req(xrst), .o_irq_req(irq),
    .o_irq_enabled(irq_en), .o_stack_full(sfull), .o_port_a(port));
  cmw_top #(.RESTART(RST)) dut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rc32k_tick(tick),
    .i_xtal32k_tick(tick), .i_halt(halt), .i_wdt_clear(wclr_in), .i_wdt_overflow(wovf),
    .i_ext_reset_req(xrst), .i_irq_req(irq), .i_irq_enabled(irq_en), .i_stack_full(sfull),
    .i_port_a(port), .o_core_clk_en(core_en), .o_sub_clk_en(sub_en),
    .o_display_clk_en(disp), .o_aux_clk_en(aux), .o_fast_osc_on(fast_on),
    .o_cpu_run(cpu_run), .o_wdt_clear(wclr), .o_wdt_run(wrun), .o_system_reset(srst),
    .o_wdt_reset(wrst), .o_pcsp_reset(pcsp), .o_resume(res), .o_irq_take(take));
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int k;
    @(posedge i_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd
  // Bounded wait for the next resume pulse
  task automatic wait_res(input int base);
    int k;
    k = 0;
    while (cnt[0] == base && k < 3000) begin
      @(posedge i_clk);
      k++;
    end
    chk(32'(k < 3000), 32'h1);
    @(posedge i_clk);
  endtask : wait_res
  ////////////////////////////////////////////////////////////////////////
  // Reset values, read-only status, unmapped place
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(CMW_OFS_CLOCK_MODE, 32'h1);
    rd(CMW_OFS_WAKE_MASK, 32'h0);
    wr(CMW_OFS_STATUS, 32'hFF);
    rd(CMW_OFS_STATUS, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk(32'(e), 32'h1);
  endtask : t_regs
  // Slow modes from the select bit and divider field
  task automatic t_modes();
    wr(CMW_OFS_CLOCK_MODE, 32'h30);
    rd(CMW_OFS_STATUS, {27'h0, CMW_MODE_SLOW0, 2'h0});
    chk(32'(fast_on), 32'h0);
    wr(CMW_OFS_CLOCK_MODE, 32'h10);
    rd(CMW_OFS_STATUS, {27'h0, CMW_MODE_SLOW1, 2'h0});
    chk(32'(fast_on), 32'h1);
    wr(CMW_OFS_CLOCK_MODE, 32'h01);
    rd(CMW_OFS_STATUS, {27'h0, CMW_MODE_NORMAL, 2'h0});
    chk(32'(core_en), 32'h1);
  endtask : t_modes
  // Sleep, masked pin ignored, enabled pin wakes after the wait
  task automatic t_sleep();
    wr(CMW_OFS_WAKE_MASK, 32'h01);
    wr(CMW_OFS_CLOCK_MODE, 32'h05);
    b = cnt;
    core.halt();
    repeat (2) @(posedge i_clk);
    chk(32'(cpu_run), 32'h0);
    chk(32'(fast_on), 32'h0);
    chk(32'(core_en), 32'h0);
    chk(32'(wrun), 32'h1);
    chk(32'(cnt[4] - b[4]), 32'h1);
    rd(CMW_OFS_STATUS, {27'h0, CMW_MODE_SLEEP, 2'h1});
    b = cnt;
    core.fall(1);
    repeat (40) @(posedge i_clk);
    chk(32'(cnt[0] - b[0]), 32'h0);
    chk(32'(cnt[5] - b[5] + cnt[6] - b[6]), 32'h0);
    chk(32'(cnt[8] - b[8] >= 10 && cnt[8] - b[8] <= 12), 32'h1);
    t0 = cyc;
    core.fall(0);
    wait_res(b[0]);
    chk(32'(t_res - t0 >= RST && t_res - t0 <= RST + 6), 32'h1);
    repeat (2) @(posedge i_clk);
    chk(32'(cpu_run), 32'h1);
  endtask : t_sleep
  // Idle keeps display and aux clocks, watchdog wake and flags
  task automatic t_idle();
    wr(CMW_OFS_CLOCK_MODE, 32'h07);
    core.halt();
    b = cnt;
    repeat (320) @(posedge i_clk);
    chk(32'(cnt[5] - b[5] >= 9 && cnt[5] - b[5] <= 11), 32'h1);
    chk(32'(cnt[6] - b[6] >= 79 && cnt[6] - b[6] <= 81), 32'h1);
    chk(32'(cnt[8] - b[8] >= 79 && cnt[8] - b[8] <= 81), 32'h1);
    rd(CMW_OFS_STATUS, {27'h0, CMW_MODE_IDLE, 2'h1});
    b = cnt;
    core.pulse(3'h2);
    wait_res(b[0]);
    chk(32'(cnt[2] - b[2]), 32'h1);
    rd(CMW_OFS_STATUS, {27'h0, CMW_MODE_NORMAL, 2'h3});
    core.pulse(3'h1);
    rd(CMW_OFS_STATUS, {27'h0, CMW_MODE_NORMAL, 2'h2});
    b = cnt;
    core.pulse(3'h2);
    repeat (2) @(posedge i_clk);
    chk(32'(cnt[7] - b[7]), 32'h1);
  endtask : t_idle
  // Pending request, reset wake, serviced and deferred interrupts
  task automatic t_irq();
    wr(CMW_OFS_CLOCK_MODE, 32'h03);
    core.irq(3'h4);
    core.halt();
    b = cnt;
    repeat (40) @(posedge i_clk);
    chk(32'(cnt[0] - b[0]), 32'h0);
    chk(32'(cnt[5] - b[5]), 32'h0);
    core.pulse(3'h4);
    wait_res(b[0]);
    chk(32'(cnt[3] - b[3]), 32'h1);
    core.irq(3'h0);
    core.halt();
    b = cnt;
    t0 = cyc;
    core.irq(3'h6);
    wait_res(b[0]);
    chk(32'(cnt[1] - b[1]), 32'h1);
    chk(32'(t_res - t0 > RST), 32'h1);
    core.irq(3'h0);
    core.halt();
    b = cnt;
    core.irq(3'h5);
    wait_res(b[0]);
    chk(32'(cnt[1] - b[1]), 32'h0);
    core.irq(3'h0);
  endtask : t_irq
  ////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Hang guard, well beyond the expected run
  initial begin
    #3ms;
    n_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_modes();
    t_sleep();
    t_idle();
    t_irq();
    wrap_up();
  end
endmodule : tb_clock_mode_and_wakeup_control
`default_nettype wire
